// *** src/iflm_map.svh ***
// Constants of the interrupt flag and mask logic: offsets, fields, resets.
// Assumes it is included by its bare name from the package and the modules.
`ifndef IFLM_MAP_SVH
`define IFLM_MAP_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define IFLM_NUM_SRC 8
`define IFLM_ADDR_W 8

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IFLM_OFF_FLAG 8'h00
`define IFLM_OFF_MASK 8'h04
`define IFLM_OFF_STATUS 8'h08

// ----------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------
`define IFLM_FLAG_RST 8'h00
`define IFLM_MASK_RST 8'h00
`define IFLM_WORD_ZERO 32'h0000_0000
`define IFLM_ST_LOCK 0
`define IFLM_ST_ONE_SEEN 1
`define IFLM_ST_TWO_SEEN 2
`define IFLM_ST_NMI_PEND 3
`define IFLM_ST_IRQ_REQ 4
`define IFLM_RESP_OKAY 2'h0
`define IFLM_RESP_DECERR 2'h3

`endif

// *** src/iflm_pkg.sv ***
// Types shared by the interrupt flag and mask logic.
// Assumes iflm_map.svh is on the include path.
`include "iflm_map.svh"

package iflm_pkg;

	// Stack-pointer lockout states
	typedef enum logic [1:0] {
		IFLM_LOCKED = 2'h0,
		IFLM_WAIT_TWO = 2'h1,
		IFLM_WAIT_ONE = 2'h2,
		IFLM_OPEN = 2'h3
	} iflm_lock_t;

	// One bit per interrupt source
	typedef logic [`IFLM_NUM_SRC-1:0] iflm_vec_t;

endpackage

// *** src/iflm_flag_if.sv ***
// Carrier between the controller and its factor flag bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface iflm_flag_if;
	iflm_pkg::iflm_vec_t setEvent;
	iflm_pkg::iflm_vec_t clearReq;
	iflm_pkg::iflm_vec_t flags;

	modport bank(input setEvent, input clearReq, output flags);
	modport ctrl(output setEvent, output clearReq, input flags);
endinterface

`default_nettype wire

// *** src/iflm_flag_bank.sv ***
// Sticky interrupt factor flags, set by events, cleared by request.
// Assumes set and clear arrive on clk from logic of the same domain.
`timescale 1ns/1ps
`default_nettype none
`include "iflm_map.svh"

module iflm_flag_bank (
	input wire logic clk,
	input wire logic reset_n,
	iflm_flag_if.bank port
);

	iflm_pkg::iflm_vec_t flags;
	iflm_pkg::iflm_vec_t next_flags;
	iflm_pkg::iflm_vec_t clearOnly;

	// ------------------------------------------------------------------
	// Flag update
	// ------------------------------------------------------------------

	// Set term applied last so a same-cycle event survives the clear
	always_comb begin
		next_flags = flags & ~port.clearReq;
		next_flags = next_flags | port.setEvent;
	end

	// Register the flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags <= `IFLM_FLAG_RST;
		end else begin
			flags <= next_flags;
		end
	end

	assign port.flags = flags;
	assign clearOnly = port.clearReq & ~port.setEvent;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------

	a_event_sets_flag: assert property (
		@(posedge clk) disable iff (!reset_n)
		(port.setEvent != `IFLM_FLAG_RST) |=>
			((flags & $past(port.setEvent)) == $past(port.setEvent)))
		else $error("event did not set its flag");

	a_write_one_clears: assert property (
		@(posedge clk) disable iff (!reset_n)
		(clearOnly != `IFLM_FLAG_RST) |=>
			((flags & $past(clearOnly)) == `IFLM_FLAG_RST))
		else $error("write of one did not clear flag");

	a_untouched_flag_holds: assert property (
		@(posedge clk) disable iff (!reset_n)
		((port.setEvent | port.clearReq) == `IFLM_FLAG_RST) |=>
			$stable(flags))
		else $error("flag changed without cause");

endmodule

`default_nettype wire

// *** src/iflm_top.sv ***
// Interrupt flag, mask and stack-pointer lockout logic with AXI4-Lite
// registers. Assumes sources, core strobes and the bus share clk; core
// strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "iflm_map.svh"

module iflm_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [`IFLM_NUM_SRC-1:0] srcEvent,
	input wire logic nmiEvent,
	input wire logic nmiAccept,
	input wire logic globalEnable,
	input wire logic returnFromInterruptInstr,
	input wire logic stackPointerOneWrite,
	input wire logic stackPointerTwoWrite,
	output logic irqRequest,
	output logic irqRetrigger,
	output logic nmiRequest,
	output logic lockoutActive,
	input wire logic [`IFLM_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`IFLM_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	iflm_flag_if flagBus ();
	iflm_pkg::iflm_lock_t lockState;
	iflm_pkg::iflm_lock_t next_lockState;
	iflm_pkg::iflm_vec_t mask;
	iflm_pkg::iflm_vec_t next_mask;
	iflm_pkg::iflm_vec_t flags;
	logic nmiPending;
	logic next_nmiPending;
	logic reqPrev;
	logic next_reqPrev;
	logic next_irqRetrigger;
	logic awHeld;
	logic next_awHeld;
	logic [`IFLM_ADDR_W-1:0] awAddr;
	logic [`IFLM_ADDR_W-1:0] next_awAddr;
	logic wHeld;
	logic next_wHeld;
	logic [31:0] wData;
	logic [31:0] next_wData;
	logic [3:0] wStrb;
	logic [3:0] next_wStrb;
	logic bvalid;
	logic next_bvalid;
	logic [1:0] bresp;
	logic [1:0] next_bresp;
	logic rvalid;
	logic next_rvalid;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [1:0] rresp;
	logic [1:0] next_rresp;
	logic doWrite;
	logic hitFlag;
	logic hitMask;
	logic [31:0] statusWord;

	// ------------------------------------------------------------------
	// Factor flags
	// ------------------------------------------------------------------

	// Events set flags directly, mask plays no part here
	assign flagBus.setEvent = srcEvent;
	// Write of one to a flag bit clears it, low byte lane only
	assign flagBus.clearReq = (doWrite && hitFlag && wStrb[0]) ?
		wData[`IFLM_NUM_SRC-1:0] : `IFLM_FLAG_RST;
	assign flags = flagBus.flags;

	iflm_flag_bank flagBank (
		.clk(clk),
		.reset_n(reset_n),
		.port(flagBus.bank)
	);

	// ------------------------------------------------------------------
	// Stack-pointer lockout
	// ------------------------------------------------------------------

	// Both pointers must be written before interrupts pass; a lone
	// write reopens the wait for its partner
	always_comb begin
		next_lockState = lockState;
		unique case (lockState)
			iflm_pkg::IFLM_LOCKED, iflm_pkg::IFLM_OPEN: begin
				if (stackPointerOneWrite && stackPointerTwoWrite) begin
					next_lockState = iflm_pkg::IFLM_OPEN;
				end else if (stackPointerOneWrite) begin
					next_lockState = iflm_pkg::IFLM_WAIT_TWO;
				end else if (stackPointerTwoWrite) begin
					next_lockState = iflm_pkg::IFLM_WAIT_ONE;
				end
			end
			iflm_pkg::IFLM_WAIT_TWO: begin
				if (stackPointerTwoWrite) begin
					next_lockState = iflm_pkg::IFLM_OPEN;
				end
			end
			iflm_pkg::IFLM_WAIT_ONE: begin
				if (stackPointerOneWrite) begin
					next_lockState = iflm_pkg::IFLM_OPEN;
				end
			end
		endcase
	end

	// Register lockout state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lockState <= iflm_pkg::IFLM_LOCKED;
		end else begin
			lockState <= next_lockState;
		end
	end

	// Pairing by software keeps the window closed only briefly
	assign lockoutActive = (lockState != iflm_pkg::IFLM_OPEN);

	// ------------------------------------------------------------------
	// Requests to the core
	// ------------------------------------------------------------------

	// Maskable request is a level that holds while any unmasked flag stands, global enable is set and lockout is off
	assign irqRequest = ((flags & mask) != `IFLM_FLAG_RST) &&
		globalEnable && !lockoutActive;
	// Non-maskable request is still held back by the lockout
	assign nmiRequest = nmiPending && !lockoutActive;

	// NMI pending latch and re-request pulse; event wins over accept
	always_comb begin
		next_nmiPending = (nmiPending && !nmiAccept) || nmiEvent;
		next_reqPrev = irqRequest;
		// Fresh assertion or return with a cause still set
		next_irqRetrigger = irqRequest &&
			(!reqPrev || returnFromInterruptInstr);
	end

	// Register request state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nmiPending <= 1'b0;
			reqPrev <= 1'b0;
			irqRetrigger <= 1'b0;
		end else begin
			nmiPending <= next_nmiPending;
			reqPrev <= next_reqPrev;
			irqRetrigger <= next_irqRetrigger;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite write side
	// ------------------------------------------------------------------
	assign s_axi_awready = !awHeld && !bvalid;
	assign s_axi_wready = !wHeld && !bvalid;
	assign doWrite = awHeld && wHeld && !bvalid;
	assign hitFlag = ({awAddr[`IFLM_ADDR_W-1:2], 2'h0} == `IFLM_OFF_FLAG);
	assign hitMask = ({awAddr[`IFLM_ADDR_W-1:2], 2'h0} == `IFLM_OFF_MASK);

	// Address and data held apart, then retired together
	always_comb begin
		next_awHeld = awHeld;
		next_awAddr = awAddr;
		next_wHeld = wHeld;
		next_wData = wData;
		next_wStrb = wStrb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_mask = mask;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			// Status register is read-only but answers OKAY
			if (hitFlag || hitMask ||
				({awAddr[`IFLM_ADDR_W-1:2], 2'h0} == `IFLM_OFF_STATUS)) begin
				next_bresp = `IFLM_RESP_OKAY;
			end else begin
				next_bresp = `IFLM_RESP_DECERR;
			end
			if (hitMask && wStrb[0]) begin
				next_mask = wData[`IFLM_NUM_SRC-1:0];
			end
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	// Register write side
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld <= 1'b0;
			awAddr <= '0;
			wHeld <= 1'b0;
			wData <= `IFLM_WORD_ZERO;
			wStrb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `IFLM_RESP_OKAY;
			mask <= `IFLM_MASK_RST;
		end else begin
			awHeld <= next_awHeld;
			awAddr <= next_awAddr;
			wHeld <= next_wHeld;
			wData <= next_wData;
			wStrb <= next_wStrb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			mask <= next_mask;
		end
	end

	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;

	// ------------------------------------------------------------------
	// AXI4-Lite read side
	// ------------------------------------------------------------------

	// Status view of the block's own state
	always_comb begin
		statusWord = `IFLM_WORD_ZERO;
		statusWord[`IFLM_ST_LOCK] = lockoutActive;
		statusWord[`IFLM_ST_ONE_SEEN] =
			(lockState == iflm_pkg::IFLM_WAIT_TWO) ||
			(lockState == iflm_pkg::IFLM_OPEN);
		statusWord[`IFLM_ST_TWO_SEEN] =
			(lockState == iflm_pkg::IFLM_WAIT_ONE) ||
			(lockState == iflm_pkg::IFLM_OPEN);
		statusWord[`IFLM_ST_NMI_PEND] = nmiPending;
		statusWord[`IFLM_ST_IRQ_REQ] = irqRequest;
	end

	assign s_axi_arready = !rvalid;

	// One read in flight; data captured when the address is taken
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = `IFLM_RESP_OKAY;
			next_rdata = `IFLM_WORD_ZERO;
			unique case ({s_axi_araddr[`IFLM_ADDR_W-1:2], 2'h0})
				`IFLM_OFF_FLAG: next_rdata[`IFLM_NUM_SRC-1:0] = flags;
				`IFLM_OFF_MASK: next_rdata[`IFLM_NUM_SRC-1:0] = mask;
				`IFLM_OFF_STATUS: next_rdata = statusWord;
				default: next_rresp = `IFLM_RESP_DECERR;
			endcase
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// Register read side
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid <= 1'b0;
			rdata <= `IFLM_WORD_ZERO;
			rresp <= `IFLM_RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------

	a_locked_blocks_all: assert property (
		@(posedge clk) disable iff (!reset_n)
		lockoutActive |-> (!irqRequest && !nmiRequest))
		else $error("interrupt passed during lockout");

	a_release_needs_write: assert property (
		@(posedge clk) disable iff (!reset_n)
		$fell(lockoutActive) |->
			($past(stackPointerOneWrite) || $past(stackPointerTwoWrite)))
		else $error("lockout released without pointer write");

	a_lone_write_relocks: assert property (
		@(posedge clk) disable iff (!reset_n)
		(!lockoutActive && (stackPointerOneWrite != stackPointerTwoWrite))
			|=> lockoutActive)
		else $error("single pointer write left lockout open");

	a_partner_still_owed: assert property (
		@(posedge clk) disable iff (!reset_n)
		(lockState == iflm_pkg::IFLM_WAIT_TWO && !stackPointerTwoWrite)
			|=> lockoutActive)
		else $error("lockout opened without second pointer");

	a_request_gating: assert property (
		@(posedge clk) disable iff (!reset_n)
		irqRequest |-> (globalEnable && ((flags & mask) != 8'h00)))
		else $error("request without enable or masked flag");

	a_request_on_cause: assert property (
		@(posedge clk) disable iff (!reset_n)
		(globalEnable && !lockoutActive && ((flags & mask) != 8'h00))
			|-> irqRequest)
		else $error("request missing with cause present");

	a_retrigger_on_return: assert property (
		@(posedge clk) disable iff (!reset_n)
		(returnFromInterruptInstr && irqRequest) |=> irqRetrigger)
		else $error("no re-request after return");

	a_retrigger_on_enable: assert property (
		@(posedge clk) disable iff (!reset_n)
		($rose(globalEnable) && irqRequest) |=> irqRetrigger)
		else $error("no request pulse when enable rose");

	a_write_response: assert property (
		@(posedge clk) disable iff (!reset_n)
		doWrite |=> (s_axi_bvalid && !awHeld && !wHeld))
		else $error("write not answered next cycle");

endmodule

`default_nettype wire

// *** tb/iflm_core_model.sv ***
// Behavioural model of the CPU core beside the interrupt logic.
// Assumes one clock; strobes change only by NBA after rising edges.
`timescale 1ns/1ps
`default_nettype none

module iflm_core_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic nmiRequest,
	output logic globalEnable,
	output logic returnFromInterruptInstr,
	output logic stackPointerOneWrite,
	output logic stackPointerTwoWrite,
	output logic nmiAccept
);
	int ackDelay = 0;
	int waitCnt = 0;

	// Quiet core at time zero
	initial begin
		globalEnable = 1'b0;
		returnFromInterruptInstr = 1'b0;
		stackPointerOneWrite = 1'b0;
		stackPointerTwoWrite = 1'b0;
	end

	// Takes a raised NMI after ackDelay cycles, one-cycle pulse
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nmiAccept <= 1'b0;
			waitCnt <= 0;
		end else if (nmiRequest && !nmiAccept && waitCnt < ackDelay) begin
			waitCnt <= waitCnt + 1;
		end else begin
			nmiAccept <= nmiRequest && !nmiAccept;
			waitCnt <= 0;
		end
	end

	// Pointer loads; init code passes both, a lone one only on command
	task loadPair(input logic one, input logic two);
		@(posedge clk);
		stackPointerOneWrite <= one;
		stackPointerTwoWrite <= two;
		@(posedge clk);
		stackPointerOneWrite <= 1'b0;
		stackPointerTwoWrite <= 1'b0;
		#1;
	endtask

	// Global enable, driven to v after the next rising edge
	task setEnable(input logic v);
		@(posedge clk);
		globalEnable <= v;
		#1;
	endtask

	// One return-from-interrupt instruction
	task retInstr;
		@(posedge clk);
		returnFromInterruptInstr <= 1'b1;
		@(posedge clk);
		returnFromInterruptInstr <= 1'b0;
		#1;
	endtask
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the interrupt flag and mask logic.
// Assumes the design files and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "iflm_map.svh"

module testbench;
	logic clk, reset_n, nmiEvent, ta, tw;
	logic [7:0] srcEvent, awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata, rdata, word;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic awready, wready, bvalid, arready, rvalid;
	logic en, ret, spOne, spTwo, nmiAccept;
	logic irqRequest, irqRetrigger, nmiRequest, lockoutActive;
	logic [15:0] rnd;
	int nMismatch = 0, numChecks = 0, mFlag = 0, mMask = 0, mLock = 1;

	iflm_top DUT (.clk(clk), .reset_n(reset_n), .srcEvent(srcEvent),
		.nmiEvent(nmiEvent), .nmiAccept(nmiAccept), .globalEnable(en),
		.returnFromInterruptInstr(ret), .stackPointerOneWrite(spOne),
		.stackPointerTwoWrite(spTwo), .irqRequest(irqRequest),
		.irqRetrigger(irqRetrigger), .nmiRequest(nmiRequest),
		.lockoutActive(lockoutActive), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	iflm_core_model core (.clk(clk), .reset_n(reset_n),
		.nmiRequest(nmiRequest), .globalEnable(en),
		.returnFromInterruptInstr(ret), .stackPointerOneWrite(spOne),
		.stackPointerTwoWrite(spTwo), .nmiAccept(nmiAccept));

	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		nMismatch++;
		wrapUp();
	end

	function logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function logic expIrq();
		return ((mFlag & mMask) != 0) && (en === 1'b1) && (mLock == 0);
	endfunction

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		numChecks++;
		if (g !== e) begin
			nMismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bus write; sampled at negedge, released after the taking edge
	task axiWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!((ta || !awvalid) && (tw || !wvalid)));
		do begin
			@(negedge clk);
			ta = bvalid;
			resp = bresp;
			@(posedge clk);
		end while (!ta);
		bready <= 1'b0;
		#1;
	endtask

	task axiRd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ta = arready;
			@(posedge clk);
		end while (!ta);
		arvalid <= 1'b0;
		do begin
			@(negedge clk);
			ta = rvalid;
			word = rdata;
			resp = rresp;
			@(posedge clk);
		end while (!ta);
		rready <= 1'b0;
		#1;
	endtask

	// One-cycle source and NMI events
	task pulse(input logic [7:0] e, input logic n);
		@(posedge clk);
		srcEvent <= e;
		nmiEvent <= n;
		@(posedge clk);
		srcEvent <= 8'h00;
		nmiEvent <= 1'b0;
		#1;
		mFlag = mFlag | e;
	endtask

	task wrapUp;
		if (nMismatch == 0 && numChecks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial begin
		reset_n = 1'b0;
		srcEvent = 8'h00;
		nmiEvent = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		rnd = 16'h5BA2;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		axiRd(`IFLM_OFF_FLAG);
		chk("flag", 32'h0, word);
		axiRd(`IFLM_OFF_MASK);
		chk("mask", 32'h0, word);
		axiRd(`IFLM_OFF_STATUS);
		chk("status", 32'h1, word);
		pulse(8'hA5, 1'b1);
		axiRd(`IFLM_OFF_FLAG);
		chk("flag", 32'hA5, word);
		axiWr(`IFLM_OFF_MASK, 32'hFF);
		mMask = 'hFF;
		core.setEnable(1'b1);
		chk("irqRequest", 1'b0, irqRequest);
		chk("nmiRequest", 1'b0, nmiRequest);
		core.loadPair(1'b1, 1'b0);
		core.loadPair(1'b1, 1'b0);
		chk("lockoutActive", 1'b1, lockoutActive);
		core.ackDelay = 3;
		core.loadPair(1'b0, 1'b1);
		mLock = 0;
		chk("lockoutActive", 1'b0, lockoutActive);
		chk("irqRequest", expIrq(), irqRequest);
		chk("nmiRequest", 1'b1, nmiRequest);
		repeat (8) @(posedge clk);
		#1;
		chk("nmiRequest", 1'b0, nmiRequest);
		core.setEnable(1'b0);
		chk("irqRequest", 1'b0, irqRequest);
		core.setEnable(1'b1);
		@(posedge clk);
		#1;
		chk("irqRetrigger", 1'b1, irqRetrigger);
		@(posedge clk);
		#1;
		chk("irqRetrigger", 1'b0, irqRetrigger);
		core.retInstr();
		chk("irqRetrigger", 1'b1, irqRetrigger);
		for (int i = 0; i < 16; i++) begin
			rnd = lfsrNext(rnd);
			mMask = rnd[7:0];
			axiWr(`IFLM_OFF_MASK, {24'h0, rnd[7:0]});
			chk("bresp", `IFLM_RESP_OKAY, resp);
			rnd = lfsrNext(rnd);
			pulse(rnd[7:0], rnd[0]);
			chk("irqRequest", expIrq(), irqRequest);
			axiWr(`IFLM_OFF_FLAG, {24'h0, rnd[15:8]});
			mFlag = mFlag & ~int'(rnd[15:8]);
			axiRd(`IFLM_OFF_FLAG);
			chk("flag", mFlag, word);
			chk("rresp", `IFLM_RESP_OKAY, resp);
			chk("irqRequest", expIrq(), irqRequest);
		end
		core.loadPair(1'b0, 1'b1);
		mLock = 1;
		chk("lockoutActive", 1'b1, lockoutActive);
		chk("irqRequest", expIrq(), irqRequest);
		axiRd(`IFLM_OFF_STATUS);
		chk("status", 32'h5, word);
		core.loadPair(1'b1, 1'b0);
		mLock = 0;
		chk("lockoutActive", 1'b0, lockoutActive);
		chk("irqRequest", expIrq(), irqRequest);
		core.loadPair(1'b1, 1'b1);
		chk("lockoutActive", 1'b0, lockoutActive);
		axiRd(8'h0C);
		chk("rresp", `IFLM_RESP_DECERR, resp);
		chk("rdata", 32'h0, word);
		axiWr(8'h10, 32'hFF);
		chk("bresp", `IFLM_RESP_DECERR, resp);
		@(posedge clk);
		reset_n <= 1'b0;
		@(posedge clk);
		reset_n <= 1'b1;
		mFlag = 0;
		mLock = 1;
		axiWr(`IFLM_OFF_MASK, 32'hFF);
		mMask = 'hFF;
		pulse(8'h0F, 1'b1);
		chk("lockoutActive", 1'b1, lockoutActive);
		chk("irqRequest", expIrq(), irqRequest);
		chk("nmiRequest", 1'b0, nmiRequest);
		axiRd(`IFLM_OFF_FLAG);
		chk("flag", mFlag, word);
		wrapUp();
	end
endmodule

`default_nettype wire
